// *** design/fcl_cfg_check.sv ***
`timescale 1ns/1ps
`default_nettype none
module fcl_cfg_check (
    input wire logic [11:0] cfg,
    input wire logic [31:0] cycle_ns,
    input wire logic [31:0] pulses,
    output logic param_err,
    output logic comm_warn,
    output logic enc_comb,
    output logic fcl_allowed
);
    logic fcl_en;
    logic [1:0] axes;
    logic [1:0] mode;
    logic mode_ok;
    logic pulses_ok;

    assign fcl_en = cfg[fcl_pkg::FCL_CFG_FCL_EN];
    assign axes = cfg[fcl_pkg::FCL_CFG_AXES_LO +: 2];
    assign mode = cfg[fcl_pkg::FCL_CFG_MODE_LO +: 2];
    assign mode_ok = (mode == fcl_pkg::FCL_MODE_POSITION)
        || (mode == fcl_pkg::FCL_MODE_POSITIONING);
    assign pulses_ok = (pulses >= fcl_pkg::FCL_PULSES_MIN)
        && (pulses <= fcl_pkg::FCL_PULSES_MAX);

    always_comb begin
        param_err = 1'b0;
        comm_warn = 1'b0;
        enc_comb = 1'b0;
        if (fcl_en) begin
            if (axes == fcl_pkg::FCL_AXES_3) begin
                param_err = 1'b1;
            end
            if (!mode_ok || !pulses_ok) begin
                param_err = 1'b1;
            end
            if (cfg[fcl_pkg::FCL_CFG_ABZ_MOTOR]) begin
                param_err = 1'b1;
            end
            if (cfg[fcl_pkg::FCL_CFG_LOOP_FUNC] && cfg[fcl_pkg::FCL_CFG_ABS_DET]) begin
                param_err = 1'b1;
            end
            if (axes == fcl_pkg::FCL_AXES_1 && cycle_ns < fcl_pkg::FCL_CYC_1AX_NS) begin
                comm_warn = 1'b1;
            end
            if (axes == fcl_pkg::FCL_AXES_2 && cycle_ns < fcl_pkg::FCL_CYC_2AX_NS) begin
                comm_warn = 1'b1;
            end
            if (axes == fcl_pkg::FCL_AXES_2) begin
                enc_comb = cfg[fcl_pkg::FCL_CFG_ABZ_LOAD]
                    || cfg[fcl_pkg::FCL_CFG_FOUR_WIRE];
            end
        end
    end

    assign fcl_allowed = fcl_en && !param_err && !enc_comb;
endmodule // fcl_cfg_check
`default_nettype wire

// *** design/fcl_dual_filter.sv ***
`timescale 1ns/1ps
`default_nettype none
module fcl_dual_filter (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [31:0] motor_pos,
    input wire logic [31:0] load_pos,
    input wire logic [1:0] method,
    input wire logic motor_stopped,
    input wire logic [15:0] band,
    output logic [31:0] pos_out
);
    logic [31:0] target;
    logic signed [32:0] diff;
    logic signed [49:0] prod;
    logic [31:0] step;
    logic [31:0] acc_reg;
    logic [31:0] acc_next;

    always_comb begin
        target = motor_pos;
        if (method == 2'(fcl_pkg::FCL_FULL)) begin
            target = load_pos;
        end else if (method == 2'(fcl_pkg::FCL_DUAL)) begin
            target = motor_stopped ? load_pos : motor_pos;
        end
    end

    assign diff = $signed({target[31], target}) - $signed({acc_reg[31], acc_reg});
    assign prod = diff * $signed({1'b0, band});
    assign step = prod[fcl_pkg::FCL_FILTER_SHIFT +: 32];

    always_comb begin
        acc_next = acc_reg + step;
        if (method != 2'(fcl_pkg::FCL_DUAL)) begin
            acc_next = target;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_reg <= 32'h0000_0000;
        end else begin
            acc_reg <= acc_next;
        end
    end

    assign pos_out = acc_reg;
endmodule // fcl_dual_filter
`default_nettype wire

// *** design/fcl_feedback_select.sv ***
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module fcl_feedback_select (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [31:0] motor_pos,
    input wire logic [31:0] load_pos,
    input wire logic motor_stopped,
    input wire logic loop_select_input,
    input wire logic factory_fresh,
    output logic [31:0] feedback_pos,
    output logic [1:0] active_method,
    output logic parameter_error_alarm,
    output logic comm_cycle_warning,
    output logic encoder_combination_alarm,
    output logic motor_combination_error,
    output logic irq
);
    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [11:0] cfg_reg;
    logic [31:0] cycle_reg;
    logic [15:0] filter_reg;
    logic [31:0] pulses_reg;
    logic [3:0] status_reg;
    logic [3:0] mask_reg;
    logic [3:0] alarm_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic irq_reg;
    logic [31:0] fb_reg;
    logic [1:0] method_reg;
    logic [1:0] method_next;
    logic boot_done_reg;
    logic [3:0] events;
    logic param_err;
    logic comm_warn;
    logic enc_comb;
    logic fcl_allowed;
    logic motor_comb;
    logic [31:0] filt_pos;
    logic setup;
    logic access;
    logic wr_en;

    function automatic logic is_mapped(input logic [31:0] addr);
        logic [7:0] off;
        off = addr[7:0];
        is_mapped = (addr[31:8] == 24'h00_0000) && (off[1:0] == 2'h0)
            && (off <= fcl_pkg::FCL_OFF_ALARM);
    endfunction

    function automatic logic hit(input logic [31:0] addr, input logic [7:0] off);
        hit = is_mapped(addr) && (addr[7:0] == off);
    endfunction

    assign setup = psel && !penable;
    assign access = psel && penable && pready_reg;
    assign wr_en = access && pwrite && is_mapped(paddr);

    // ------------------------------------------------------------
    // Configuration checks and filter
    // ------------------------------------------------------------
    fcl_cfg_check u_check (
        .cfg(cfg_reg),
        .cycle_ns(cycle_reg),
        .pulses(pulses_reg),
        .param_err(param_err),
        .comm_warn(comm_warn),
        .enc_comb(enc_comb),
        .fcl_allowed(fcl_allowed)
    );

    fcl_dual_filter u_filter (
        .pclk(pclk),
        .presetn(presetn),
        .motor_pos(motor_pos),
        .load_pos(load_pos),
        .method(method_reg),
        .motor_stopped(motor_stopped),
        .band(filter_reg),
        .pos_out(filt_pos)
    );

    // ------------------------------------------------------------
    // Control method selection
    // ------------------------------------------------------------
    always_comb begin
        method_next = 2'(fcl_pkg::FCL_SEMI);
        if (fcl_allowed) begin
            if (!cfg_reg[fcl_pkg::FCL_CFG_LOOP_FUNC]) begin
                method_next = 2'(fcl_pkg::FCL_DUAL);
            end else if (cfg_reg[fcl_pkg::FCL_CFG_LOOP_CMD] || loop_select_input) begin
                method_next = 2'(fcl_pkg::FCL_DUAL);
            end
            if (method_next == 2'(fcl_pkg::FCL_DUAL)
                && filter_reg == fcl_pkg::FCL_FILTER_FULL) begin
                method_next = 2'(fcl_pkg::FCL_FULL);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            method_reg <= 2'(fcl_pkg::FCL_SEMI);
            fb_reg <= 32'h0000_0000;
        end else begin
            method_reg <= method_next;
            fb_reg <= filt_pos;
        end
    end

    // ------------------------------------------------------------
    // Power-up check for factory state
    // ------------------------------------------------------------
    // First configuration after power-up decides the check
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_done_reg <= 1'b0;
        end else if (wr_en && hit(paddr, fcl_pkg::FCL_OFF_CFG)) begin
            boot_done_reg <= 1'b1;
        end
    end

    assign motor_comb = !boot_done_reg && factory_fresh
        && wr_en && hit(paddr, fcl_pkg::FCL_OFF_CFG)
        && pwdata[fcl_pkg::FCL_CFG_FCL_EN] && pwdata[fcl_pkg::FCL_CFG_ABS_DET]
        && !pwdata[fcl_pkg::FCL_CFG_REPL_PREP];

    always_comb begin
        events = 4'h0;
        events[fcl_pkg::FCL_EV_PARAM] = param_err;
        events[fcl_pkg::FCL_EV_COMM] = comm_warn;
        events[fcl_pkg::FCL_EV_ENC] = enc_comb;
        events[fcl_pkg::FCL_EV_MOTOR] = motor_comb;
    end

    // ------------------------------------------------------------
    // Writable registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_reg <= fcl_pkg::FCL_CFG_RST;
            cycle_reg <= fcl_pkg::FCL_CYCLE_RST;
            filter_reg <= fcl_pkg::FCL_FILTER_RST;
            pulses_reg <= fcl_pkg::FCL_PULSES_RST;
            mask_reg <= fcl_pkg::FCL_MASK_RST;
        end else if (wr_en) begin
            if (hit(paddr, fcl_pkg::FCL_OFF_CFG)) begin
                cfg_reg <= pwdata[fcl_pkg::FCL_CFG_WIDTH-1:0];
            end
            if (hit(paddr, fcl_pkg::FCL_OFF_CYCLE)) begin
                cycle_reg <= pwdata;
            end
            if (hit(paddr, fcl_pkg::FCL_OFF_FILTER)) begin
                filter_reg <= pwdata[15:0];
            end
            if (hit(paddr, fcl_pkg::FCL_OFF_PULSES)) begin
                pulses_reg <= pwdata;
            end
            if (hit(paddr, fcl_pkg::FCL_OFF_MASK)) begin
                mask_reg <= pwdata[fcl_pkg::FCL_NUM_EV-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Sticky status and latched alarms
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < fcl_pkg::FCL_NUM_EV; gi++) begin : g_ev
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    status_reg[gi] <= 1'b0;
                    alarm_reg[gi] <= 1'b0;
                end else begin
                    if (events[gi]) begin
                        status_reg[gi] <= 1'b1;
                    end else if (wr_en && hit(paddr, fcl_pkg::FCL_OFF_STATUS) && pwdata[gi]) begin
                        status_reg[gi] <= 1'b0;
                    end
                    if (events[gi]) begin
                        alarm_reg[gi] <= 1'b1;
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(status_reg & mask_reg);
        end
    end

    // ------------------------------------------------------------
    // APB read path and answer
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= 1'b1;
            if (setup) begin
                pslverr_reg <= !is_mapped(paddr);
                prdata_reg <= 32'h0000_0000;
                case (paddr[7:0])
                    fcl_pkg::FCL_OFF_CFG: begin
                        prdata_reg <= {20'h0_0000, cfg_reg};
                    end
                    fcl_pkg::FCL_OFF_CYCLE: begin
                        prdata_reg <= cycle_reg;
                    end
                    fcl_pkg::FCL_OFF_FILTER: begin
                        prdata_reg <= {16'h0000, filter_reg};
                    end
                    fcl_pkg::FCL_OFF_PULSES: begin
                        prdata_reg <= pulses_reg;
                    end
                    fcl_pkg::FCL_OFF_STATUS: begin
                        prdata_reg <= {28'h000_0000, status_reg};
                    end
                    fcl_pkg::FCL_OFF_MASK: begin
                        prdata_reg <= {28'h000_0000, mask_reg};
                    end
                    fcl_pkg::FCL_OFF_STATE: begin
                        prdata_reg <= {29'h0, motor_stopped, method_reg};
                    end
                    fcl_pkg::FCL_OFF_ALARM: begin
                        prdata_reg <= {28'h000_0000, alarm_reg};
                    end
                    default: begin
                        prdata_reg <= 32'h0000_0000;
                    end
                endcase
                if (!is_mapped(paddr)) begin
                    prdata_reg <= 32'h0000_0000;
                end
            end
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign irq = irq_reg;
    assign feedback_pos = fb_reg;
    assign active_method = method_reg;
    assign parameter_error_alarm = alarm_reg[fcl_pkg::FCL_EV_PARAM];
    assign comm_cycle_warning = alarm_reg[fcl_pkg::FCL_EV_COMM];
    assign encoder_combination_alarm = alarm_reg[fcl_pkg::FCL_EV_ENC];
    assign motor_combination_error = alarm_reg[fcl_pkg::FCL_EV_MOTOR];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_three_axis_alarm: assert property (
        cfg_reg[fcl_pkg::FCL_CFG_FCL_EN] && cfg_reg[9:8] == fcl_pkg::FCL_AXES_3
        |-> ##1 parameter_error_alarm && method_reg == 2'(fcl_pkg::FCL_SEMI))
        else $error("three-axis fully closed not refused");
    chk_mode_gate: assert property (
        method_reg != 2'(fcl_pkg::FCL_SEMI) |-> $past(cfg_reg[11:10]) <= 2'h1)
        else $error("fully closed outside position modes");
    chk_cycle_one_axis: assert property (
        cfg_reg[0] && cfg_reg[9:8] == fcl_pkg::FCL_AXES_1
        && cycle_reg < fcl_pkg::FCL_CYC_1AX_NS |-> ##1 comm_cycle_warning)
        else $error("short cycle not warned on one axis");
    chk_cycle_two_axis: assert property (
        cfg_reg[0] && cfg_reg[9:8] == fcl_pkg::FCL_AXES_2
        && cycle_reg < fcl_pkg::FCL_CYC_2AX_NS |-> ##1 status_reg[1])
        else $error("short cycle not warned on two axes");
    chk_abz_two_axis: assert property (
        cfg_reg[0] && cfg_reg[5] && cfg_reg[9:8] == fcl_pkg::FCL_AXES_2
        |-> ##1 encoder_combination_alarm)
        else $error("encoder combination not flagged");
    chk_semi_motor: assert property (
        $past(method_reg) == 2'(fcl_pkg::FCL_SEMI) |=> fb_reg == $past(motor_pos, 2))
        else $error("semi closed not on motor position");
    chk_full_force: assert property (
        method_reg == 2'(fcl_pkg::FCL_DUAL) |-> filter_reg != fcl_pkg::FCL_FILTER_FULL
        || $changed(filter_reg) || $changed(cfg_reg))
        else $error("dual switching despite full setting");
    chk_abs_switch: assert property (
        cfg_reg[0] && cfg_reg[1] && cfg_reg[2] |-> ##1 status_reg[0] ##1 parameter_error_alarm)
        else $error("switchable with absolute not flagged");
    chk_alarm_hold: assert property (
        $rose(parameter_error_alarm) |-> parameter_error_alarm [*8])
        else $error("alarm did not stay latched");
    chk_irq_level: assert property (
        |(status_reg & mask_reg) |=> irq)
        else $error("interrupt not raised");

    cov_dual: cover property (method_reg == 2'(fcl_pkg::FCL_DUAL) ##1 !motor_stopped);
    cov_full: cover property (method_reg == 2'(fcl_pkg::FCL_FULL));
    cov_switch: cover property (cfg_reg[1] && loop_select_input && method_reg != 2'h0);
    cov_irq: cover property ($rose(irq));
endmodule // fcl_feedback_select
`default_nettype wire

// *** design/fcl_pkg.sv ***
// Operation
// - Fully closed loop on three axes: parameter alarm
// - Fully closed only in position or positioning
// - One axis, cycle below 125 us: warning
// - Two axes, cycle below 250 us: warning
// - Differential rotary load encoder on two axes: alarm
// - Semi closed always uses motor position
// - Dual feedback: load stopped, motor moving
// - Filter setting 4500 forces fully closed
// - Filter band comes from filter setting
// - Fully closed position in load counts
// - Loop function select picks semi or full
// - Factory power-up with absolute: motor combination error
// - Switchable mode with absolute: parameter alarm
// - Switchable: unassigned input off, command picks
package fcl_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] FCL_OFF_CFG = 8'h00;
    localparam logic [7:0] FCL_OFF_CYCLE = 8'h04;
    localparam logic [7:0] FCL_OFF_FILTER = 8'h08;
    localparam logic [7:0] FCL_OFF_PULSES = 8'h0C;
    localparam logic [7:0] FCL_OFF_STATUS = 8'h10;
    localparam logic [7:0] FCL_OFF_MASK = 8'h14;
    localparam logic [7:0] FCL_OFF_STATE = 8'h18;
    localparam logic [7:0] FCL_OFF_ALARM = 8'h1C;
    // ------------------------------------------------------------
    // Configuration field positions
    // ------------------------------------------------------------
    localparam int FCL_CFG_FCL_EN = 0;
    localparam int FCL_CFG_LOOP_FUNC = 1;
    localparam int FCL_CFG_ABS_DET = 2;
    localparam int FCL_CFG_REPL_PREP = 3;
    localparam int FCL_CFG_LOOP_CMD = 4;
    localparam int FCL_CFG_ABZ_LOAD = 5;
    localparam int FCL_CFG_ABZ_MOTOR = 6;
    localparam int FCL_CFG_FOUR_WIRE = 7;
    localparam int FCL_CFG_AXES_LO = 8;
    localparam int FCL_CFG_MODE_LO = 10;
    localparam int FCL_CFG_WIDTH = 12;
    // Event bits in status, mask and alarm registers
    localparam int FCL_EV_PARAM = 0;
    localparam int FCL_EV_COMM = 1;
    localparam int FCL_EV_ENC = 2;
    localparam int FCL_EV_MOTOR = 3;
    localparam int FCL_NUM_EV = 4;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [11:0] FCL_CFG_RST = 12'h100;
    localparam logic [31:0] FCL_CYCLE_RST = 32'h0003_D090;
    localparam logic [15:0] FCL_FILTER_RST = 16'h0000;
    localparam logic [31:0] FCL_PULSES_RST = 32'h0000_1000;
    localparam logic [3:0] FCL_MASK_RST = 4'h0;
    // ------------------------------------------------------------
    // Limits and encodings
    // ------------------------------------------------------------
    localparam int FCL_CYC_1AX_US = 125;
    localparam int FCL_CYC_2AX_US = 250;
    localparam logic [31:0] FCL_CYC_1AX_NS = 32'(FCL_CYC_1AX_US * 1000);
    localparam logic [31:0] FCL_CYC_2AX_NS = 32'(FCL_CYC_2AX_US * 1000);
    localparam logic [31:0] FCL_PULSES_MIN = 32'h0000_1000;
    localparam logic [31:0] FCL_PULSES_MAX = 32'h0400_0000;
    localparam logic [15:0] FCL_FILTER_FULL = 16'h1194;
    localparam int FCL_FILTER_SHIFT = 12;
    localparam logic [1:0] FCL_AXES_1 = 2'h1;
    localparam logic [1:0] FCL_AXES_2 = 2'h2;
    localparam logic [1:0] FCL_AXES_3 = 2'h3;
    localparam logic [1:0] FCL_MODE_POSITION = 2'h0;
    localparam logic [1:0] FCL_MODE_POSITIONING = 2'h1;

    typedef enum logic [1:0] {
        FCL_SEMI,
        FCL_DUAL,
        FCL_FULL
    } fcl_method_t;
endpackage : fcl_pkg

// *** sim/fcl_enc_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module fcl_enc_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic step,
    output logic [31:0] motor_pos,
    output logic [31:0] load_pos
);
    // Positions move only on request, 16-bit range keeps blend exact
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            motor_pos <= 32'h0000_0000;
            load_pos <= 32'h0000_0000;
        end else if (step) begin
            motor_pos <= {16'h0000, 16'($urandom())};
            load_pos <= {16'h0000, 16'($urandom())};
        end
    end
endmodule // fcl_enc_model
`default_nettype wire

// *** sim/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
    $display("ERROR %s exp %0h got %0h", n, e, g); end end
module testbench;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = '0, pwdata = '0, prdata, feedback_pos, motor_pos, load_pos, rd;
    logic pready, pslverr, irq, step = 1'b0, stopped = 1'b0, lin = 1'b0, er;
    logic [1:0] active_method, me;
    logic pe, cw, ea, mc, ff = 1'b0;
    logic [3:0] al;
    int bad_count = 0, comparisons = 0, cycles_run = 0;
    // Semi, dual, full, switchable, alarm and boundary cases
    logic [11:0] cfgs [16] = '{12'h100, 12'h101, 12'h101, 12'h103, 12'h113, 12'h103,
        12'h301, 12'h901, 12'h107, 12'h101, 12'h101, 12'h201, 12'h201, 12'h221,
        12'h121, 12'h281};
    logic [31:0] cycs [16] = '{250000, 250000, 250000, 250000, 250000, 250000, 250000,
        250000, 250000, 124999, 125000, 249999, 250000, 250000, 250000, 250000};
    logic [31:0] rst_vals [8] = '{32'h100, 32'h3D090, 0, 32'h1000, 0, 0, 0, 0};

    always #4 pclk = ~pclk;

    fcl_feedback_select dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .motor_pos(motor_pos),
        .load_pos(load_pos), .motor_stopped(stopped), .loop_select_input(lin),
        .factory_fresh(ff), .feedback_pos(feedback_pos), .active_method(active_method),
        .parameter_error_alarm(pe), .comm_cycle_warning(cw),
        .encoder_combination_alarm(ea), .motor_combination_error(mc), .irq(irq));

    fcl_enc_model enc_u (.pclk(pclk), .presetn(presetn), .step(step),
        .motor_pos(motor_pos), .load_pos(load_pos));

    // ------------------------------------------------------------
    // Reference model
    // ------------------------------------------------------------
    function automatic logic [3:0] m_alarm(logic [11:0] c, logic [31:0] cy);
        logic [1:0] ax;
        ax = c[9:8];
        m_alarm = 4'h0;
        m_alarm[0] = (c[0] && (ax == 2'h3 || c[11:10] > 2'h1)) || (c[1] && c[2]);
        m_alarm[1] = c[0] && ((ax == 2'h1 && cy < 125000) || (ax == 2'h2 && cy < 250000));
        m_alarm[2] = c[0] && ax == 2'h2 && (c[5] || c[7]);
    endfunction

    function automatic logic [1:0] m_meth(logic [11:0] c, logic [3:0] a, bit full, logic l);
        if (!c[0] || a[0] || a[2]) return 2'h0;
        if (!c[1] || c[4] || l) return full ? 2'h2 : 2'h1;
        return 2'h0;
    endfunction

    // ------------------------------------------------------------
    // Bus and control tasks
    // ------------------------------------------------------------
    task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task do_reset();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
    endtask

    task wrap_up();
        if (bad_count == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cycles_run++;
        if (cycles_run == 5000) begin
            bad_count++;
            wrap_up();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(28));
        do_reset();
        for (int a = 0; a < 8; a++) begin
            apb(1'b0, 32'(a * 4), 32'h0);
            `CHK("reset_value", rst_vals[a], rd)
        end
        apb(1'b0, 32'h20, 32'h0);
        `CHK("unmapped_err", 1'b1, er)
        for (int i = 0; i < 16; i++) begin
            do_reset();
            apb(1'b1, 32'h00, 32'(cfgs[i]));
            apb(1'b1, 32'h04, cycs[i]);
            apb(1'b1, 32'h08, (i == 2) ? 32'd4500 : 32'd4096);
            al = m_alarm(cfgs[i], cycs[i]);
            for (int s = 0; s < 2; s++) begin
                @(posedge pclk);
                stopped <= s[0];
                lin <= (i == 5);
                step <= 1'b1;
                @(posedge pclk);
                step <= 1'b0;
                repeat (6) @(posedge pclk);
                me = m_meth(cfgs[i], al, i == 2, i == 5);
                `CHK("method", me, active_method)
                `CHK("position", (me == 2'h0) ? motor_pos : ((me == 2'h2 || s == 1) ?
                    load_pos : motor_pos), feedback_pos)
            end
            apb(1'b0, 32'h1C, 32'h0);
            `CHK("alarm_reg", {28'h0, al}, rd)
            `CHK("alarm_pins", al, {mc, ea, cw, pe})
        end
        ff <= 1'b1;
        do_reset();
        apb(1'b1, 32'h00, 32'h105);
        apb(1'b0, 32'h1C, 32'h0);
        `CHK("motor_comb", 32'h8, rd)
        `CHK("motor_comb_pin", 1'b1, mc)
        ff <= 1'b0;
        do_reset();
        apb(1'b1, 32'h00, 32'h101);
        apb(1'b1, 32'h04, 32'd100000);
        repeat (3) @(posedge pclk);
        `CHK("irq_masked", 1'b0, irq)
        apb(1'b1, 32'h14, 32'h2);
        repeat (3) @(posedge pclk);
        `CHK("irq_raised", 1'b1, irq)
        apb(1'b1, 32'h04, 32'd250000);
        apb(1'b1, 32'h10, 32'h2);
        repeat (3) @(posedge pclk);
        apb(1'b0, 32'h10, 32'h0);
        `CHK("status_clear", 32'h0, rd)
        `CHK("irq_clear", 1'b0, irq)
        apb(1'b0, 32'h1C, 32'h0);
        `CHK("alarm_latched", 32'h2, rd)
        `CHK("warn_latched", 1'b1, cw)
        wrap_up();
    end
endmodule // testbench
`default_nettype wire
